// ### src/pcc_pkg.sv
// Constants, register map and carrier types for the pixel clip control.
// Assumes one 100 MHz clock shared with the scaler output stage.
`default_nettype none

package pcc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [7:0] ADDR_CLIP_CTRL = 8'h78;
  localparam logic [7:0] ADDR_SEQ_CMD = 8'h80;
  localparam logic [7:0] ADDR_MASK = 8'h84;
  localparam logic [7:0] ADDR_MASK_WR = 8'h88;
  localparam logic [7:0] ADDR_STATUS = 8'h8C;

  ////////////////////////////////////////////////////////////////////////
  // Clip control word layout and reset values
  localparam logic [15:0] CLIP_CTRL_RST = 16'h0000;
  localparam logic [15:0] CLIP_CTRL_USED = 16'h037B;
  localparam logic [15:0] MASK_RST = 16'hFFFF;
  localparam int KEY_SEL_LSB = 8;
  localparam int SRC_SEL_LSB = 4;
  localparam int RECT_IL_BIT = 3;
  localparam int WB_SEL_LSB = 0;
  localparam int STAT_PEND_BIT = 16;
  localparam int STAT_BUSY_BIT = 17;
  localparam int STAT_IDLE_BIT = 18;
  localparam int SEQ_ARM_BIT = 0;

  ////////////////////////////////////////////////////////////////////////
  // Field encodings
  typedef enum logic [2:0] {
    SRC_OFF = 3'h0,
    SRC_ALPHA = 3'h1,
    SRC_RSV2 = 3'h2,
    SRC_RSV3 = 3'h3,
    SRC_RECT = 3'h4,
    SRC_RECT_INV = 3'h5,
    SRC_MASK = 3'h6,
    SRC_MASK_INV = 3'h7
  } pcc_src_t;

  typedef enum logic [1:0] {
    WB_OFF = 2'h0,
    WB_KEY = 2'h1,
    WB_MASK_KEY = 2'h2,
    WB_APPLIED = 2'h3
  } pcc_wb_t;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h1,
    SEQ_WAIT = 3'h2,
    SEQ_UPLOAD = 3'h4
  } pcc_seq_t;

  ////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic valid;
    logic [11:0] x;
    logic [11:0] y;
    logic field_even;
    logic key;
    logic mask_bit;
    logic [7:0] alpha;
  } pcc_pix_t;

  typedef struct packed {
    logic valid;
    logic [11:0] left;
    logic [11:0] right;
    logic [11:0] top;
    logic [11:0] bottom;
  } pcc_rect_t;

  typedef struct packed {
    logic valid;
    logic bit_val;
  } pcc_wb_bit_t;

endpackage

`default_nettype wire

// ### src/pcc_upload_seq.sv
// Video event tracking and wait-for-event upload sequencer.
// Assumes the vertical gate comes from scaler logic on the same clock.
`default_nettype none

module pcc_upload_seq (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic arm_i,
  input wire logic vgate_i,
  output logic upload_o,
  output logic busy_o,
  output logic pending_o,
  output logic idle_o
);
  import pcc_pkg::*;

  logic vgate_q;
  logic done_pulse;
  logic win_start;
  pcc_seq_t state;
  pcc_seq_t next_state;

  ////////////////////////////////////////////////////////////////////////
  // Event detection
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vgate_q <= 1'b0;
    end else begin
      vgate_q <= vgate_i;
    end
  end

  assign done_pulse = vgate_q & ~vgate_i;
  assign win_start = vgate_i & ~vgate_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      idle_o <= 1'b0;
    end else if (done_pulse) begin
      idle_o <= 1'b1;
    end else if (win_start) begin
      idle_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pending_o <= 1'b0;
    end else if (done_pulse) begin
      pending_o <= 1'b1;
    end else if (upload_o) begin
      pending_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      SEQ_IDLE: begin
        if (arm_i) next_state = SEQ_WAIT;
      end
      SEQ_WAIT: begin
        if (pending_o && idle_o && !vgate_i) next_state = SEQ_UPLOAD;
      end
      SEQ_UPLOAD: next_state = SEQ_IDLE;
      default: next_state = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= SEQ_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign upload_o = (state == SEQ_UPLOAD);
  assign busy_o = (state != SEQ_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_upload_clears_pend: assert property (@(posedge clk_i)
    disable iff (!resetn_i) upload_o && !done_pulse |=> !pending_o)
    else $error("pending event not cleared by upload");
  a_upload_in_idle: assert property (@(posedge clk_i)
    disable iff (!resetn_i) upload_o |-> $past(idle_o) && !$past(vgate_i))
    else $error("upload outside idle interval");
  a_one_upload: assert property (@(posedge clk_i)
    disable iff (!resetn_i) upload_o |=> !upload_o ##1 !upload_o)
    else $error("event caused several uploads");
  a_wait_holds: assert property (@(posedge clk_i)
    disable iff (!resetn_i) busy_o && !pending_o && !upload_o |=> !upload_o)
    else $error("upload without pending event");

endmodule // pcc_upload_seq

`default_nettype wire

// ### src/pcc_top.sv
// Pixel clip control: APB registers, clip decision, alpha and writeback.
// Assumes pixel, rectangle and gate inputs come from logic on clk_i.
//
// Behaviour
// - Key select bits 9:8 pass or clip key
// - Key clip OR-ed with list/mask clip
// - Source 000 frees channel two for U
// - Source 001 reads alpha, no clipping
// - Source 100/101 rectangle list, plain/inverted
// - Source 110/111 bit mask; 010/011 reserved
// - Bit 3 selects interlaced rectangle handling
// - Odd field lines lie above even
// - Writeback 00 frees channel three
// - Writeback 01 key, 10 masked, 11 applied
// - Sequencer waits for scaler done video event
// - Masked write changes selected bits only
// - One upload per event occurrence
// - Pending event cleared after its upload
// - Scaler done marks idle upload interval
//
// Implementation choice: the APB register port.
`default_nettype none

module pcc_top (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic vgate_i,
  input wire pcc_pkg::pcc_pix_t pix_i,
  input wire pcc_pkg::pcc_rect_t rect_i,
  output logic pix_write_o,
  output logic [7:0] alpha_o,
  output pcc_pkg::pcc_wb_bit_t wb_o,
  output logic ch2_reads_o,
  output logic ch2_u_write_o,
  output logic ch3_free_o
);
  import pcc_pkg::*;

  logic [15:0] shadow;
  logic [15:0] active;
  logic [15:0] mask;
  logic [31:0] next_rdata;
  logic setup;
  logic wr;
  logic mapped;
  logic arm;
  logic upload;
  logic busy;
  logic pending;
  logic idle;
  logic [1:0] key_sel;
  pcc_src_t src_sel;
  logic rect_il;
  pcc_wb_t wb_sel;
  logic [11:0] line;
  logic rect_hit;
  logic key_clip;
  logic src_clip;
  logic clip;
  logic mask_key;

  ////////////////////////////////////////////////////////////////////////
  // APB slave
  assign setup = psel_i & ~penable_i;
  assign wr = psel_i & penable_i & pwrite_i;
  assign pready_o = 1'b1;

  always_comb begin
    mapped = 1'b1;
    next_rdata = 32'h0000_0000;
    unique case (paddr_i)
      ADDR_CLIP_CTRL: next_rdata = {16'h0000, shadow & CLIP_CTRL_USED};
      ADDR_SEQ_CMD: next_rdata = {31'h0000_0000, busy};
      ADDR_MASK: next_rdata = {16'h0000, mask};
      ADDR_MASK_WR: next_rdata = 32'h0000_0000;
      ADDR_STATUS: begin
        next_rdata[15:0] = active;
        next_rdata[STAT_PEND_BIT] = pending;
        next_rdata[STAT_BUSY_BIT] = busy;
        next_rdata[STAT_IDLE_BIT] = idle;
      end
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (setup) begin
      prdata_o <= pwrite_i ? 32'h0000_0000 : next_rdata;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pslverr_o <= 1'b0;
    end else if (setup) begin
      pslverr_o <= ~mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Staged clip control word
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shadow <= CLIP_CTRL_RST;
    end else if (wr && paddr_i == ADDR_CLIP_CTRL) begin
      shadow <= pwdata_i[15:0] & CLIP_CTRL_USED;
    end else if (wr && paddr_i == ADDR_MASK_WR) begin
      shadow <= ((shadow & ~mask) | (pwdata_i[15:0] & mask))
        & CLIP_CTRL_USED;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mask <= MASK_RST;
    end else if (wr && paddr_i == ADDR_MASK) begin
      mask <= pwdata_i[15:0];
    end
  end

  assign arm = wr && paddr_i == ADDR_SEQ_CMD && pwdata_i[SEQ_ARM_BIT];

  pcc_upload_seq u_seq (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .arm_i(arm),
    .vgate_i(vgate_i),
    .upload_o(upload),
    .busy_o(busy),
    .pending_o(pending),
    .idle_o(idle)
  );

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      active <= CLIP_CTRL_RST;
    end else if (upload) begin
      active <= shadow;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Field decode
  assign key_sel = active[KEY_SEL_LSB +: 2];
  assign src_sel = pcc_src_t'(active[SRC_SEL_LSB +: 3]);
  assign rect_il = active[RECT_IL_BIT];
  assign wb_sel = pcc_wb_t'(active[WB_SEL_LSB +: 2]);

  ////////////////////////////////////////////////////////////////////////
  // Rectangle hit
  // interlaced rectangle mapping
  assign line = rect_il ? {pix_i.y[10:0], pix_i.field_even} : pix_i.y;
  assign rect_hit = rect_i.valid
    && pix_i.x >= rect_i.left && pix_i.x <= rect_i.right
    && line >= rect_i.top && line <= rect_i.bottom;

  ////////////////////////////////////////////////////////////////////////
  // Clip decision
  // key clip select
  assign key_clip = key_sel[1] & (pix_i.key ^ key_sel[0]);

  always_comb begin
    src_clip = 1'b0;
    unique case (src_sel)
      SRC_RECT: src_clip = rect_hit;
      SRC_RECT_INV: src_clip = ~rect_hit;
      SRC_MASK: src_clip = pix_i.mask_bit;
      SRC_MASK_INV: src_clip = ~pix_i.mask_bit;
      SRC_ALPHA: src_clip = 1'b0;
      SRC_RSV2, SRC_RSV3: src_clip = 1'b0;
      SRC_OFF: src_clip = 1'b0;
    endcase
  end

  assign clip = key_clip | src_clip;
  assign mask_key = src_clip | pix_i.key;

  assign pix_write_o = pix_i.valid & ~clip;

  ////////////////////////////////////////////////////////////////////////
  // Transfer channel usage
  // channel two writes U
  assign ch2_u_write_o = (src_sel == SRC_OFF);
  assign ch2_reads_o = src_sel == SRC_ALPHA || src_sel[2];
  assign ch3_free_o = (wb_sel == WB_OFF);

  ////////////////////////////////////////////////////////////////////////
  // Alpha output
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      alpha_o <= 8'h00;
    end else if (pix_i.valid) begin
      if (src_sel == SRC_ALPHA) begin
        alpha_o <= pix_i.alpha;
      end else begin
        alpha_o <= {8{pix_i.key ^ (key_sel == 2'h1)}};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clip writeback
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wb_o <= '0;
    end else begin
      wb_o.valid <= pix_i.valid && wb_sel != WB_OFF;
      unique case (wb_sel)
        WB_KEY: wb_o.bit_val <= pix_i.key;
        WB_MASK_KEY: wb_o.bit_val <= mask_key;
        WB_APPLIED: wb_o.bit_val <= clip;
        WB_OFF: wb_o.bit_val <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_key_clip_on: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    pix_i.valid && key_sel == 2'h3 && !pix_i.key |-> !pix_write_o)
    else $error("inverted key did not clip");
  a_key_no_clip: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    pix_i.valid && !key_sel[1] && !src_sel[2] |-> pix_write_o)
    else $error("pixel clipped with clipping off");
  a_or_combine: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    pix_i.valid && key_clip && !src_clip |-> !pix_write_o)
    else $error("key clip lost in OR");
  a_ch2_free: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    src_sel == SRC_OFF |-> ch2_u_write_o && !ch2_reads_o)
    else $error("channel two not freed");
  a_alpha_sub: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    pix_i.valid && src_sel == SRC_ALPHA && !upload
    |=> alpha_o == $past(pix_i.alpha))
    else $error("read alpha not substituted");
  a_rect_inv: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    pix_i.valid && src_sel == SRC_RECT_INV && !rect_hit |-> !pix_write_o)
    else $error("inverted rectangle did not clip");
  a_mask_clip: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    pix_i.valid && src_sel == SRC_MASK && pix_i.mask_bit |-> !pix_write_o)
    else $error("mask bit did not clip");
  a_wb_off: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    wb_sel == WB_OFF && !upload |=> !wb_o.valid)
    else $error("writeback while disabled");
  a_wb_applied: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    pix_i.valid && wb_sel == WB_APPLIED
    |=> wb_o.valid && wb_o.bit_val == !$past(pix_write_o))
    else $error("applied clip not written back");
  a_masked_write: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    wr && paddr_i == ADDR_MASK_WR
    |=> (shadow & ~$past(mask)) == ($past(shadow) & ~$past(mask)))
    else $error("masked write changed unselected bits");
  a_reserved_zero: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    setup && !pwrite_i && paddr_i == ADDR_CLIP_CTRL
    |=> prdata_o[15:10] == 6'h00 && !prdata_o[7] && !prdata_o[2])
    else $error("reserved bits read nonzero");
  a_ctrl_upload: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    !upload |=> active == $past(active))
    else $error("active word changed without upload");

  c_upload: cover property (@(posedge clk_i) disable iff (!resetn_i)
    upload);
  c_rect_clip: cover property (@(posedge clk_i) disable iff (!resetn_i)
    pix_i.valid && src_sel == SRC_RECT && rect_hit && rect_il);
  c_key_and_mask: cover property (@(posedge clk_i) disable iff (!resetn_i)
    pix_i.valid && key_clip && src_clip);
  c_unmapped: cover property (@(posedge clk_i) disable iff (!resetn_i)
    psel_i && penable_i && pslverr_o);

endmodule // pcc_top

`default_nettype wire

// ### tb/pcc_gate_model.sv
// Behavioural vertical gate source standing in for the scaler output.
// Assumes start_i is a one-cycle pulse on clk_i.
`default_nettype none

module pcc_gate_model #(
  parameter int WIN_LEN = 6
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic start_i,
  output logic vgate_o
);
  int cnt;

  ////////////////////////////////////////////////////////////////////////
  // window then idle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt <= 0;
    end else if (start_i) begin
      cnt <= WIN_LEN;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end

  assign vgate_o = (cnt > 0);
endmodule // pcc_gate_model

`default_nettype wire

// ### tb/pcc_top_tb_top.sv
// Self-checking bench for the pixel clip control block.
// Assumes the pcc package and the gate model on the same clock.
`default_nettype none

module pcc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pcc_pkg::*;

  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, vgate, pix_write, ch2_r, ch2_u, ch3_f;
  logic gate_start = 1'b0;
  logic [7:0] alpha;
  pcc_pix_t pix = '0;
  pcc_rect_t rect = '{1'b1, 12'd10, 12'd20, 12'd5, 12'd8};
  pcc_wb_bit_t wb;
  logic [1:0] ksel, wsel;
  logic [2:0] ssel;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;

  always #5 clk_i = ~clk_i;

  pcc_top dut_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .vgate_i(vgate), .pix_i(pix), .rect_i(rect),
    .pix_write_o(pix_write), .alpha_o(alpha), .wb_o(wb),
    .ch2_reads_o(ch2_r), .ch2_u_write_o(ch2_u), .ch3_free_o(ch3_f)
  );

  pcc_gate_model gate_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .start_i(gate_start),
    .vgate_o(vgate)
  );

  ////////////////////////////////////////////////////////////////////////
  // Reporting
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus and video tasks
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r,
      output logic e);
    apb(1'b0, a, 32'h0, r, e);
  endtask

  task automatic frame();
    int k;
    @(posedge clk_i);
    gate_start <= 1'b1;
    @(posedge clk_i);
    gate_start <= 1'b0;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (vgate !== 1'b0 && k < 40);
  endtask

  task automatic wait_up(output logic [31:0] r);
    logic e;
    int k;
    k = 0;
    do begin
      rd(ADDR_STATUS, r, e);
      k++;
    end while (r[STAT_BUSY_BIT] !== 1'b0 && k < 20);
  endtask

  task automatic load_cfg(input logic [15:0] w);
    logic [31:0] r;
    wr(ADDR_CLIP_CTRL, {16'h0, w});
    wr(ADDR_SEQ_CMD, 32'h1);
    frame();
    wait_up(r);
    chk("status", {13'h0, 3'b100, w & CLIP_CTRL_USED}, r);
  endtask

  task automatic pixel(input logic [11:0] x, input logic [11:0] y,
      input logic fe, input logic k, input logic m, input logic hit);
    logic kc, sc, clip, wexp;
    logic [7:0] a;
    kc = ksel[1] & (k ^ ksel[0]);
    case (ssel)
      3'h4: sc = hit;
      3'h5: sc = !hit;
      3'h6: sc = m;
      3'h7: sc = !m;
      default: sc = 1'b0;
    endcase
    clip = kc | sc;
    a = (ssel == 3'h1) ? 8'hA5 : {8{k ^ (ksel == 2'h1)}};
    wexp = (wsel == 2'h1) ? k : (wsel == 2'h2) ? (sc | k) : clip;
    @(posedge clk_i);
    pix <= '{1'b1, x, y, fe, k, m, 8'hA5};
    #1;
    chk("pix_write", {31'h0, !clip}, {31'h0, pix_write});
    @(posedge clk_i);
    pix.valid <= 1'b0;
    #1;
    chk("alpha", {24'h0, a}, {24'h0, alpha});
    if (wsel != 2'h0) begin
      chk("wb", {30'h0, 1'b1, wexp}, {30'h0, wb});
    end else begin
      chk("wb_off", 32'h0, {30'h0, wb});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic regs();
    logic [31:0] r;
    logic e;
    rd(ADDR_CLIP_CTRL, r, e);
    chk("clip_rst", {16'h0, CLIP_CTRL_RST}, r);
    rd(ADDR_MASK, r, e);
    chk("mask_rst", {16'h0, MASK_RST}, r);
    rd(ADDR_STATUS, r, e);
    chk("status_rst", 32'h0, r);
    rd(8'h90, r, e);
    chk("unmapped", 32'h1, {31'h0, e});
    wr(ADDR_CLIP_CTRL, 32'hFFFF_FFFF);
    rd(ADDR_CLIP_CTRL, r, e);
    chk("clip_rsv", 32'h0000_037B, r);
    wr(ADDR_CLIP_CTRL, 32'h0000_0301);
    wr(ADDR_MASK, 32'h0000_0070);
    wr(ADDR_MASK_WR, 32'h0000_FF4F);
    rd(ADDR_CLIP_CTRL, r, e);
    chk("masked_wr", 32'h0000_0341, r);
    wr(ADDR_MASK, 32'h0000_FFFF);
    chk("no_upload", 32'h1, {31'h0, ch3_f});
  endtask

  task automatic cfg_sweep();
    logic ch2_exp;
    for (int i = 0; i < 32; i++) begin
      ksel = 2'(i);
      ssel = 3'(i / 4);
      wsel = 2'(i + i / 4);
      ch2_exp = ssel == 3'h1 || ssel[2];
      load_cfg({6'h0, ksel, 1'b0, ssel, 2'b00, wsel});
      chk("ch2_reads", {31'h0, ch2_exp}, {31'h0, ch2_r});
      chk("ch2_u", {31'h0, ssel == 3'h0}, {31'h0, ch2_u});
      chk("ch3_free", {31'h0, wsel == 2'h0}, {31'h0, ch3_f});
      for (int j = 0; j < 4; j++) begin
        pixel(12'd10, 12'd8, 1'b0, j[0], j[1], 1'b1);
        pixel(12'd21, 12'd5, 1'b0, j[1], j[0], 1'b0);
      end
    end
  endtask

  task automatic interlace();
    ksel = 2'h0;
    ssel = 3'h4;
    wsel = 2'h3;
    load_cfg(16'h004B);
    pixel(12'd12, 12'd4, 1'b0, 1'b0, 1'b0, 1'b1);
    pixel(12'd12, 12'd4, 1'b1, 1'b0, 1'b0, 1'b0);
    pixel(12'd12, 12'd2, 1'b1, 1'b0, 1'b0, 1'b1);
  endtask

  task automatic one_per_event();
    logic [31:0] r;
    logic e;
    wr(ADDR_CLIP_CTRL, 32'h0000_0003);
    frame();
    rd(ADDR_STATUS, r, e);
    chk("pend_no_arm", 32'h0005_004B, r);
    wr(ADDR_SEQ_CMD, 32'h1);
    wait_up(r);
    chk("late_arm", 32'h0004_0003, r);
    wr(ADDR_SEQ_CMD, 32'h1);
    repeat (4) @(posedge clk_i);
    rd(ADDR_STATUS, r, e);
    chk("one_upload", 32'h0006_0003, r);
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    regs();
    cfg_sweep();
    interlace();
    // each upload done before next window
    one_per_event();
    summarize();
  end
endmodule // pcc_top_tb_top

`default_nettype wire
